// ---- hw/srf_consts.svh ----
// What this block does
// - Four pages of four 8-bit registers
// - Page 0 readable serial, parallel or staggered
// - Page 3 defined bits only in reg 3
// - No data bus inversion on scratch reads
// - MR3 bit 2 enables scratch access mode
// - Auto-precharge reads/writes behave as plain ones
// - MR3 bits 12:11 select readout format
// - MR3 bits 1:0 select active page
// - Bit 7 is A7 and first UI
// - Bank address picks register within page
// - Page 2 mirrors mode register settings
// - Temperature field encodes required refresh rate
// - Page 0 resets to default patterns
// - Fixed BL8 or BC4 only, no OTF
// - Read data after additive plus CAS latency
`ifndef SRF_CONSTS_SVH
`define SRF_CONSTS_SVH

`define SRF_MR_W 14
`define SRF_MR_CNT 7
`define SRF_MR3_EN_BIT 2
`define SRF_MR3_GEAR_BIT 3
`define SRF_MR5_CA_CLR_BIT 4
`define SRF_MR5_CRC_CLR_BIT 3
`define SRF_A_BC_BIT 12
`define SRF_PAGE0 2'h0
`define SRF_PAT0_RST 8'h55
`define SRF_PAT1_RST 8'h33
`define SRF_PAT2_RST 8'h0f
`define SRF_PAT3_RST 8'h00
`define SRF_BL_BC4_FIXED 2'h2
`define SRF_AL_MINUS1 2'h1
`define SRF_AL_MINUS2 2'h2
`define SRF_CL_BASE 7'h09
`define SRF_UI_BL8 4'h8
`define SRF_UI_BC4 4'h4
`define SRF_UI_HALF 3'h4
`define SRF_CMD_MRS_CODE 3'h0
`define SRF_CMD_REF_CODE 3'h1
`define SRF_CMD_WR_CODE 3'h4
`define SRF_CMD_RD_CODE 3'h5
`define SRF_SYNC_W 32

`endif

// ---- hw/srf_pkg.sv ----
package srf_pkg;

    typedef enum logic [1:0] {
        SRF_FMT_SERIAL = 2'b00,
        SRF_FMT_PARALLEL = 2'b01,
        SRF_FMT_STAGGER = 2'b10,
        SRF_FMT_RSVD = 2'b11
    } srf_fmt_t;

    typedef enum logic [2:0] {
        SRF_CMD_NONE = 3'b000,
        SRF_CMD_MRS = 3'b001,
        SRF_CMD_REF = 3'b010,
        SRF_CMD_RD = 3'b011,
        SRF_CMD_WR = 3'b100
    } srf_cmd_t;

    typedef enum logic {
        SRF_ST_IDLE = 1'b0,
        SRF_ST_BURST = 1'b1
    } srf_state_t;

endpackage

// ---- hw/srf_sync.sv ----
`timescale 1ns/1ns
module srf_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= d_i;
            sync_q <= meta_q;
        end
    end

    assign q_o = sync_q;
endmodule

// ---- hw/srf_scratch_regs.sv ----
`timescale 1ns/1ns
`include "srf_consts.svh"
module srf_scratch_regs #(
    parameter int DQ_W = 8,
    parameter int SLOT_AW = 7,
    parameter logic HARD_REPAIR_SUP = 1'b1,
    parameter logic SOFT_REPAIR_SUP = 1'b1,
    parameter logic BIST_REPAIR_SUP = 1'b0,
    parameter logic [1:0] TEST_TRANSP = 2'h0,
    parameter logic [3:0] MAX_ACT_CNT = 4'h0
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ck_t,
    input wire logic cs_b,
    input wire logic act_b,
    input wire logic ras_b_a16,
    input wire logic cas_b_a15,
    input wire logic we_b_a14,
    input wire logic [13:0] addr,
    input wire logic a17,
    input wire logic [1:0] bg,
    input wire logic [1:0] ba,
    input wire logic par,
    input wire logic [2:0] chip_id,
    input wire logic [1:0] temp_rate,
    input wire logic crc_err,
    output logic [DQ_W-1:0] dq_o,
    output logic dq_oe_b,
    output logic dqs_o,
    output logic dqs_oe_b,
    output logic dbi_b_o,
    output logic dbi_oe_b,
    output logic scratch_mode_o
);
    localparam int SLOTS = 1 << SLOT_AW;

    logic [`SRF_SYNC_W-1:0] raw_in;
    logic [`SRF_SYNC_W-1:0] syn;
    logic ck_s;
    logic ck_prev_q;
    logic ck_rise;
    logic ck_fall;
    logic cs_b_s;
    logic act_b_s;
    logic ras_s;
    logic cas_s;
    logic we_s;
    logic [13:0] addr_s;
    logic a17_s;
    logic [1:0] bg_s;
    logic [1:0] ba_s;
    logic par_s;
    logic [2:0] chip_s;
    logic [1:0] temp_s;
    logic crc_err_s;

    // Pins arrive from the controller's clock domain
    assign raw_in = {ck_t, cs_b, act_b, ras_b_a16, cas_b_a15, we_b_a14, addr, a17,
                     bg, ba, par, chip_id, temp_rate, crc_err};

    srf_sync #(
        .W(`SRF_SYNC_W)
    ) u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .d_i(raw_in),
        .q_o(syn)
    );

    assign ck_s = syn[31];
    assign cs_b_s = syn[30];
    assign act_b_s = syn[29];
    assign ras_s = syn[28];
    assign cas_s = syn[27];
    assign we_s = syn[26];
    assign addr_s = syn[25:12];
    assign a17_s = syn[11];
    assign bg_s = syn[10:9];
    assign ba_s = syn[8:7];
    assign par_s = syn[6];
    assign chip_s = syn[5:3];
    assign temp_s = syn[2:1];
    assign crc_err_s = syn[0];

    // Link clock edges; all pins share one synchroniser delay
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ck_prev_q <= 1'b0;
        end else begin
            ck_prev_q <= ck_s;
        end
    end

    assign ck_rise = ck_s & ~ck_prev_q;
    assign ck_fall = ~ck_s & ck_prev_q;

    function automatic srf_pkg::srf_cmd_t decode_cmd(input logic act_n, input logic [2:0] rcw);
        srf_pkg::srf_cmd_t c;
        c = srf_pkg::SRF_CMD_NONE;
        if (act_n) begin
            case (rcw)
                `SRF_CMD_MRS_CODE: c = srf_pkg::SRF_CMD_MRS;
                `SRF_CMD_REF_CODE: c = srf_pkg::SRF_CMD_REF;
                `SRF_CMD_WR_CODE: c = srf_pkg::SRF_CMD_WR;
                `SRF_CMD_RD_CODE: c = srf_pkg::SRF_CMD_RD;
                default: c = srf_pkg::SRF_CMD_NONE;
            endcase
        end
        return c;
    endfunction

    logic [`SRF_MR_W-1:0] mr_q [0:`SRF_MR_CNT-1];
    logic [2:0] mr_sel;
    logic mode_on;
    logic [1:0] page;
    logic parity_en;
    logic par_err;
    logic cmd_valid;
    srf_pkg::srf_cmd_t cmd;

    assign mr_sel = {bg_s[0], ba_s};
    assign mode_on = mr_q[3][`SRF_MR3_EN_BIT];
    assign page = mr_q[3][1:0];
    assign parity_en = |mr_q[5][2:0];
    assign par_err = ck_rise & ~cs_b_s & parity_en &
                     (^{act_b_s, ras_s, cas_s, we_s, addr_s, a17_s, bg_s, ba_s, par_s});
    // A command failing parity is dropped, not executed
    assign cmd_valid = ck_rise & ~cs_b_s & ~par_err;
    // A10 never looked at, so RDA/WRA act as RD/WR
    assign cmd = cmd_valid ? decode_cmd(act_b_s, {ras_s, cas_s, we_s}) : srf_pkg::SRF_CMD_NONE;

    // Mode registers written only by MRS
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < `SRF_MR_CNT; i++) begin
                mr_q[i] <= '0;
            end
        end else if (cmd == srf_pkg::SRF_CMD_MRS && mr_sel < 3'(`SRF_MR_CNT)) begin
            mr_q[mr_sel] <= addr_s;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            scratch_mode_o <= 1'b0;
        end else begin
            scratch_mode_o <= mode_on;
        end
    end

    logic [7:0] pat_q [0:3];

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pat_q[0] <= `SRF_PAT0_RST;
            pat_q[1] <= `SRF_PAT1_RST;
            pat_q[2] <= `SRF_PAT2_RST;
            pat_q[3] <= `SRF_PAT3_RST;
        end else if (cmd == srf_pkg::SRF_CMD_WR && mode_on && page == `SRF_PAGE0) begin
            pat_q[ba_s] <= addr_s[7:0];
        end
    end

    logic [7:0] err_lo_q;
    logic [7:0] err_hi_q;
    logic [7:0] err_bank_q;
    logic [2:0] err_chip_q;
    logic ca_err_q;
    logic crc_err_q;
    logic mr5_wr;

    assign mr5_wr = cmd == srf_pkg::SRF_CMD_MRS && mr_sel == 3'h5;

    // Frame of first failing command is held
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            err_lo_q <= 8'h00;
            err_hi_q <= 8'h00;
            err_bank_q <= 8'h00;
            err_chip_q <= 3'h0;
        end else if (par_err && !ca_err_q) begin
            err_lo_q <= addr_s[7:0];
            err_hi_q <= {cas_s, we_s, addr_s[13:8]};
            err_bank_q <= {par_s, act_b_s, bg_s, ba_s, a17_s, ras_s};
            err_chip_q <= chip_s;
        end
    end

    // Sticky status, set wins over MR5 clear
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ca_err_q <= 1'b0;
        end else if (par_err) begin
            ca_err_q <= 1'b1;
        end else if (mr5_wr && !addr_s[`SRF_MR5_CA_CLR_BIT]) begin
            ca_err_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            crc_err_q <= 1'b0;
        end else if (crc_err_s) begin
            crc_err_q <= 1'b1;
        end else if (mr5_wr && !addr_s[`SRF_MR5_CRC_CLR_BIT]) begin
            crc_err_q <= 1'b0;
        end
    end

    logic [7:0] pb [0:3][0:3];

    always_comb begin
        for (int k = 0; k < 4; k++) begin
            pb[0][k] = pat_q[k];
        end
        pb[1][0] = err_lo_q;
        pb[1][1] = err_hi_q;
        pb[1][2] = err_bank_q;
        pb[1][3] = {crc_err_q, ca_err_q, mr_q[5][2:0], err_chip_q};
        // Refresh rate code from temperature pins
        pb[2][0] = {HARD_REPAIR_SUP, SOFT_REPAIR_SUP, mr_q[2][11], temp_s, mr_q[2][12],
                    mr_q[2][10:9]};
        pb[2][1] = {mr_q[6][6], mr_q[6][5:0], mr_q[3][`SRF_MR3_GEAR_BIT]};
        pb[2][2] = {mr_q[0][6:4], mr_q[0][2], mr_q[0][12], mr_q[2][5:3]};
        pb[2][3] = {mr_q[1][10:8], mr_q[5][8:6], mr_q[1][2:1]};
        // Only reg 3 of page 3 defined
        pb[3][0] = 8'h00;
        pb[3][1] = 8'h00;
        pb[3][2] = 8'h00;
        pb[3][3] = {BIST_REPAIR_SUP, 1'b0, TEST_TRANSP, MAX_ACT_CNT};
    end

    // Read latency from MR0 and MR1
    logic [6:0] cl;
    logic [6:0] al;
    logic [7:0] rl;

    assign cl = `SRF_CL_BASE + {2'b00, mr_q[0][6:4], mr_q[0][2], mr_q[0][12]};

    always_comb begin
        case (mr_q[1][4:3])
            `SRF_AL_MINUS1: al = cl - 7'h01;
            `SRF_AL_MINUS2: al = cl - 7'h02;
            default: al = 7'h00;
        endcase
    end

    assign rl = {1'b0, cl} + {1'b0, al};

    // Delay line indexed by link cycle; reads overlap freely
    logic [9:0] slot_q [0:SLOTS-1];
    logic [SLOT_AW-1:0] cyc_q;
    logic [SLOT_AW-1:0] due_idx;
    logic rd_issue;
    logic bc4_fixed;

    // Only the fixed MR0 setting chops; OTF reads run BL8
    assign bc4_fixed = mr_q[0][1:0] == `SRF_BL_BC4_FIXED;
    assign due_idx = cyc_q + rl[SLOT_AW-1:0];
    assign rd_issue = cmd == srf_pkg::SRF_CMD_RD && mode_on;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cyc_q <= '0;
        end else if (ck_rise) begin
            cyc_q <= cyc_q + {{(SLOT_AW-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < SLOTS; i++) begin
                slot_q[i] <= '0;
            end
        end else begin
            if (ck_rise) begin
                slot_q[cyc_q] <= '0;
            end
            if (rd_issue) begin
                slot_q[due_idx] <= {1'b1, page, ba_s, mr_q[3][12:11], bc4_fixed,
                                    addr_s[2], 1'b0};
            end
        end
    end

    srf_pkg::srf_state_t state_q;
    logic [9:0] due;
    logic start;
    logic [1:0] b_page_q;
    logic [1:0] b_ba_q;
    srf_pkg::srf_fmt_t b_fmt_q;
    logic [2:0] b_ui_q;
    logic [3:0] b_left_q;

    assign due = slot_q[cyc_q];
    assign start = ck_rise & due[9];

    // BC4 runs four UIs from 0 or 4
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= srf_pkg::SRF_ST_IDLE;
            b_page_q <= 2'h0;
            b_ba_q <= 2'h0;
            b_fmt_q <= srf_pkg::SRF_FMT_SERIAL;
            b_ui_q <= 3'h0;
            b_left_q <= 4'h0;
        end else if (start) begin
            state_q <= srf_pkg::SRF_ST_BURST;
            b_page_q <= due[8:7];
            b_ba_q <= due[6:5];
            b_fmt_q <= srf_pkg::srf_fmt_t'(due[4:3]);
            b_ui_q <= (due[2] && due[1]) ? `SRF_UI_HALF : 3'h0;
            b_left_q <= due[2] ? `SRF_UI_BC4 : `SRF_UI_BL8;
        end else if ((ck_rise || ck_fall) && state_q == srf_pkg::SRF_ST_BURST) begin
            case (state_q)
                srf_pkg::SRF_ST_BURST: begin
                    if (b_left_q == 4'h1) begin
                        state_q <= srf_pkg::SRF_ST_IDLE;
                    end
                    b_ui_q <= b_ui_q + 3'h1;
                    b_left_q <= b_left_q - 4'h1;
                end
                default: state_q <= srf_pkg::SRF_ST_IDLE;
            endcase
        end
    end

    logic [DQ_W-1:0] lane_d;

    for (genvar j = 0; j < DQ_W; j++) begin : g_lane
        localparam logic [1:0] STAG = 2'(j % 4);
        localparam logic [2:0] PBIT = 3'(7 - (j % 8));
        assign lane_d[j] = (b_fmt_q == srf_pkg::SRF_FMT_PARALLEL) ? pb[b_page_q][b_ba_q][PBIT] :
                           (b_fmt_q == srf_pkg::SRF_FMT_STAGGER) ?
                           pb[b_page_q][b_ba_q + STAG][3'h7 - b_ui_q] :
                           pb[b_page_q][b_ba_q][3'h7 - b_ui_q];
    end

    // Registered pins, one clk behind the burst state
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dq_o <= '0;
            dq_oe_b <= 1'b1;
            dqs_o <= 1'b0;
            dqs_oe_b <= 1'b1;
        end else begin
            dq_o <= (state_q == srf_pkg::SRF_ST_BURST) ? lane_d : '0;
            dq_oe_b <= state_q != srf_pkg::SRF_ST_BURST;
            dqs_o <= (state_q == srf_pkg::SRF_ST_BURST) & ~b_ui_q[0];
            dqs_oe_b <= state_q != srf_pkg::SRF_ST_BURST;
        end
    end

    // Inversion flag held high, data never inverted
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dbi_b_o <= 1'b1;
            dbi_oe_b <= 1'b1;
        end else begin
            dbi_b_o <= 1'b1;
            dbi_oe_b <= state_q != srf_pkg::SRF_ST_BURST;
        end
    end
endmodule

// ---- test/srf_chk_assertions.sv ----
`timescale 1ns/1ns
module srf_chk_assertions #(
    parameter int DQ_W = 8
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic cs_b,
    input wire logic [DQ_W-1:0] dq_o,
    input wire logic dq_oe_b,
    input wire logic dqs_o,
    input wire logic dqs_oe_b,
    input wire logic dbi_b_o,
    input wire logic dbi_oe_b,
    input wire logic scratch_mode_o
);
    logic [5:0] low_cnt_q;
    // Burst length in system clocks, cleared while idle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            low_cnt_q <= 6'h00;
        end else if (dq_oe_b) begin
            low_cnt_q <= 6'h00;
        end else begin
            low_cnt_q <= low_cnt_q + 6'h01;
        end
    end
    default clocking dflt @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    dbi_held_a: assert property (dbi_b_o == 1'b1)
        else $error("inversion flag driven active");
    dbi_oe_pair_a: assert property (dbi_oe_b == dq_oe_b)
        else $error("inversion pin enable apart from data enable");
    strobe_oe_pair_a: assert property (dqs_oe_b == dq_oe_b)
        else $error("strobe enable apart from data enable");
    idle_data_a: assert property (dq_oe_b |-> dq_o == {DQ_W{1'b0}})
        else $error("data not zero while idle");
    burst_start_a: assert property ($fell(dq_oe_b) |-> dqs_o)
        else $error("strobe low on first beat");
    burst_len_a: assert property ($rose(dq_oe_b) |-> low_cnt_q == 6'h20 || low_cnt_q == 6'h10)
        else $error("burst not four or eight beats long");
    ui_hold_a: assert property (!dqs_oe_b && $changed(dqs_o) |=>
        ($stable(dqs_o) && $stable(dq_o))[*3])
        else $error("beat shorter than half a link period");
    burst_in_mode_a: assert property ($fell(dq_oe_b) |-> scratch_mode_o)
        else $error("burst outside register access mode");
    mode_by_cmd_a: assert property ($changed(scratch_mode_o) |-> $past(cs_b, 4) == 1'b0)
        else $error("mode changed without a command");
    cover property ($rose(dq_oe_b) && low_cnt_q == 6'h20);
    cover property ($rose(dq_oe_b) && low_cnt_q == 6'h10);
    cover property ($rose(scratch_mode_o));
endmodule

bind srf_scratch_regs srf_chk_assertions #(.DQ_W(DQ_W)) chk (.clk(clk), .rst_b(rst_b),
    .cs_b(cs_b), .dq_o(dq_o), .dq_oe_b(dq_oe_b), .dqs_o(dqs_o), .dqs_oe_b(dqs_oe_b),
    .dbi_b_o(dbi_b_o), .dbi_oe_b(dbi_oe_b), .scratch_mode_o(scratch_mode_o));

// ---- test/srf_ctl_model.sv ----
`timescale 1ns/1ns
module srf_ctl_model (
    input wire logic clk,
    input wire logic rst_b,
    output logic ck_t,
    output logic cs_b,
    output logic act_b,
    output logic ras_b_a16,
    output logic cas_b_a15,
    output logic we_b_a14,
    output logic [13:0] addr,
    output logic a17,
    output logic [1:0] bg,
    output logic [1:0] ba,
    output logic par
);
    logic [2:0] ph_q;
    logic flip_q;
    // Link clock of eight system clocks, free running like a bus clock
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ph_q <= 3'h0;
        end else begin
            ph_q <= ph_q + 3'h1;
        end
    end
    assign ck_t = ~ph_q[2];
    assign a17 = 1'b0;
    // Even parity, flipped on request to provoke a logged error
    assign par = ^{act_b, ras_b_a16, cas_b_a15, we_b_a14, addr, a17, bg, ba} ^ flip_q;
    initial begin
        flip_q = 1'b0;
        cs_b = 1'b1;
        act_b = 1'b1;
        {ras_b_a16, cas_b_a15, we_b_a14} = 3'h7;
        addr = 14'h0000;
        bg = 2'h0;
        ba = 2'h0;
    end
    task automatic issue(input logic [2:0] rcw, input logic [13:0] a, input logic [1:0] b,
        input logic [2:0] gx);
        @(posedge clk);
        while (ph_q != 3'h3) begin
            @(posedge clk);
        end
        cs_b <= 1'b0;
        act_b <= 1'b1;
        {ras_b_a16, cas_b_a15, we_b_a14} <= rcw;
        addr <= a;
        bg <= gx[1:0];
        flip_q <= gx[2];
        ba <= b;
        // Held one link period; released pins show the inverse (bg shows 3), not the old value
        repeat (8) @(posedge clk);
        cs_b <= 1'b1;
        act_b <= 1'b0;
        {ras_b_a16, cas_b_a15, we_b_a14} <= ~rcw;
        addr <= ~a;
        bg <= 2'h3;
        flip_q <= 1'b0;
        ba <= ~b;
    endtask
endmodule

// ---- test/tb.sv ----
`timescale 1ns/1ns
module tb;
    typedef struct packed {
        logic [1:0] f;
        logic [1:0] pg;
        logic [1:0] b;
        logic [1:0] tr;
        logic [7:0] e;
    } srf_row_t;
    logic clk, rst_b, ck_t, cs_b, act_b, ras_b_a16, cas_b_a15, we_b_a14, a17, par, crc_err;
    logic [13:0] addr;
    logic [1:0] bg, ba, temp_rate;
    logic [7:0] dq_o;
    logic dq_oe_b, dqs_o, dqs_oe_b, dbi_b_o, dbi_oe_b, scratch_mode_o;
    logic [7:0] exp_reg [4];
    logic [7:0] ui_q [8];
    int bad_count, n_compared, cyc, lat, n_ui;
    // Pages 1-3 rows all read serially
    // Page 0 rows last so exp_reg ends with the default patterns
    srf_row_t rows [15] = '{'{2'h0, 2'h1, 2'h3, 2'h1, 8'h00}, '{2'h0, 2'h2, 2'h0, 2'h0, 8'hc0},
        '{2'h0, 2'h2, 2'h0, 2'h1, 8'hc8}, '{2'h0, 2'h2, 2'h0, 2'h2, 8'hd0},
        '{2'h0, 2'h2, 2'h0, 2'h3, 8'hd8}, '{2'h0, 2'h2, 2'h1, 2'h1, 8'h00},
        '{2'h0, 2'h2, 2'h2, 2'h1, 8'h00}, '{2'h0, 2'h3, 2'h3, 2'h1, 8'h00},
        '{2'h0, 2'h0, 2'h0, 2'h1, 8'h55}, '{2'h0, 2'h0, 2'h1, 2'h1, 8'h33},
        '{2'h0, 2'h0, 2'h2, 2'h1, 8'h0f}, '{2'h0, 2'h0, 2'h3, 2'h1, 8'h00},
        '{2'h1, 2'h0, 2'h0, 2'h1, 8'h55}, '{2'h2, 2'h0, 2'h1, 2'h1, 8'h33},
        '{2'h3, 2'h0, 2'h2, 2'h1, 8'h0f}};

    srf_ctl_model ctl (.clk(clk), .rst_b(rst_b), .ck_t(ck_t), .cs_b(cs_b), .act_b(act_b),
        .ras_b_a16(ras_b_a16), .cas_b_a15(cas_b_a15), .we_b_a14(we_b_a14), .addr(addr),
        .a17(a17), .bg(bg), .ba(ba), .par(par));
    srf_scratch_regs dut (.clk(clk), .rst_b(rst_b), .ck_t(ck_t), .cs_b(cs_b), .act_b(act_b),
        .ras_b_a16(ras_b_a16), .cas_b_a15(cas_b_a15), .we_b_a14(we_b_a14), .addr(addr),
        .a17(a17), .bg(bg), .ba(ba), .par(par), .chip_id(3'h5), .temp_rate(temp_rate),
        .crc_err(crc_err), .dq_o(dq_o), .dq_oe_b(dq_oe_b), .dqs_o(dqs_o), .dqs_oe_b(dqs_oe_b),
        .dbi_b_o(dbi_b_o), .dbi_oe_b(dbi_oe_b), .scratch_mode_o(scratch_mode_o));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic stop_test();
        if (bad_count == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        n_compared++;
        if (seen !== want) begin
            bad_count++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, want);
        end
    endtask

    task automatic mode(input logic [1:0] f, input logic en, input logic [1:0] pg);
        ctl.issue(3'h0, {1'b0, f, 8'h00, en, pg}, 2'h3, 3'h0);
        @(negedge clk);
    endtask

    // Waits a bounded time for the burst, then samples each beat half a clk after it starts
    task automatic rd(input logic [1:0] b, input logic [13:0] a);
        ctl.issue(3'h5, a, b, 3'h0);
        lat = 0;
        n_ui = 0;
        while (dq_oe_b !== 1'b0 && lat < 150) begin
            @(negedge clk);
            lat++;
        end
        for (int n = 0; n < 8; n++) begin
            if (dq_oe_b === 1'b0) begin
                ui_q[n] = dq_o;
                n_ui++;
            end
            repeat (4) @(negedge clk);
        end
    endtask

    task automatic expect_burst(input logic [1:0] f, input logic [1:0] b, input int n_exp,
        input int s0);
        logic [7:0] e;
        check(8'(n_ui), 8'(n_exp)); // beat count
        if (n_exp > 0) begin
            check(8'(lat > 70 && lat < 76), 8'h01); // read latency
        end
        for (int n = 0; n < n_exp; n++) begin
            for (int j = 0; j < 8; j++) begin
                e[j] = (f == 2'h1) ? exp_reg[b][7 - j] :
                    exp_reg[(b + (f == 2'h2 ? j % 4 : 0)) % 4][7 - n - s0];
            end
            check(ui_q[n], e); // beat order
        end
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc > 12000) begin
            bad_count++;
            stop_test();
        end
    end

    initial begin
        rst_b = 1'b0;
        temp_rate = 2'h1;
        crc_err = 1'b0;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(negedge clk);
        check(8'({dq_oe_b, dqs_oe_b, dbi_b_o, dbi_oe_b, scratch_mode_o}), 8'h1e); // idle
        foreach (rows[i]) begin
            @(posedge clk);
            temp_rate <= rows[i].tr;
            mode(rows[i].f, 1'b1, rows[i].pg);
            check(8'(scratch_mode_o), 8'h01); // mode on
            exp_reg[rows[i].b] = rows[i].e;
            rd(rows[i].b, 14'h0000);
            expect_burst(rows[i].f, rows[i].b, 8, 0); // contents
        end
        mode(2'h0, 1'b1, 2'h1);
        ctl.issue(3'h4, 14'h00ff, 2'h0, 3'h0);
        exp_reg[0] = 8'h00;
        rd(2'h0, 14'h0000);
        expect_burst(2'h0, 2'h0, 8, 0); // write refused
        mode(2'h0, 1'b1, 2'h0);
        ctl.issue(3'h4, 14'h00a6, 2'h2, 3'h0);
        ctl.issue(3'h4, 14'h04c3, 2'h3, 3'h0);
        exp_reg = '{8'h55, 8'h33, 8'ha6, 8'hc3};
        rd(2'h2, 14'h0400);
        expect_burst(2'h0, 2'h2, 8, 0); // auto precharge ignored
        mode(2'h2, 1'b1, 2'h0);
        rd(2'h1, 14'h0000);
        expect_burst(2'h2, 2'h1, 8, 0); // staggered new data
        // Plain refresh between sequences, then wait
        ctl.issue(3'h1, 14'h0000, 2'h0, 3'h0);
        repeat (40) @(posedge clk);
        ctl.issue(3'h0, 14'h0001, 2'h1, 3'h1);
        ctl.issue(3'h5, 14'h0123, 2'h2, 3'h6);
        @(posedge clk);
        crc_err <= 1'b1;
        repeat (4) @(posedge clk);
        crc_err <= 1'b0;
        mode(2'h0, 1'b1, 2'h1);
        exp_reg = '{8'h23, 8'h41, 8'h69, 8'hcd};
        for (int r = 0; r < 4; r++) begin
            rd(2'(r), 14'h0000);
            expect_burst(2'h0, 2'(r), 8, 0); // error frame
        end
        ctl.issue(3'h0, 14'h0000, 2'h1, 3'h1);
        exp_reg[3] = 8'h05;
        rd(2'h3, 14'h0000);
        expect_burst(2'h0, 2'h3, 8, 0); // status cleared
        ctl.issue(3'h0, 14'h0002, 2'h0, 3'h0);
        mode(2'h0, 1'b1, 2'h0);
        exp_reg[3] = 8'hc3;
        rd(2'h3, 14'h0004);
        expect_burst(2'h0, 2'h3, 4, 4); // upper chop
        // Exit only after the last burst has drained
        repeat (8) @(posedge clk);
        mode(2'h0, 1'b0, 2'h0);
        check(8'(scratch_mode_o), 8'h00); // mode off
        rd(2'h0, 14'h0000);
        expect_burst(2'h0, 2'h0, 0, 0); // read ignored
        // Mid-run reset brings page 0 defaults back
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        mode(2'h0, 1'b1, 2'h0);
        exp_reg[2] = 8'h0f;
        rd(2'h2, 14'h0000);
        expect_burst(2'h0, 2'h2, 8, 0); // default restored
        stop_test();
    end
endmodule
